/* verilog/pps_sequencer.sv */
`timescale 1ns/1ns
`include "pps_map.svh"
module pps_sequencer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic foot_start,
	input wire logic other_key,
	input wire logic serial_event,
	input wire logic trig_n,
	input wire logic event_n,
	input wire logic prog_in_n,
	input wire logic lockout,
	input wire logic alarm_en,
	input wire logic pump_done,
	input wire logic wr_en,
	input wire logic [5:0] wr_addr,
	input wire pps_pkg::pps_phase_t wr_data,
	input wire logic [6:0] sel_label,
	input wire logic sel_go,
	output pps_pkg::pps_pump_t pump,
	output logic clear_volume,
	output logic [5:0] phase,
	output logic running,
	output logic prog_error,
	output logic range_error,
	output logic buzzer,
	output logic sel_prompt,
	output logic [6:0] sel_default,
	output logic [6:0] pause_secs
);
	// ==========================================
	// program memory, phases 1..41
	pps_pkg::pps_phase_t mem [1:`PPS_PHASE_MAX];
	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_PUMP, S_PAUSE, S_WAIT, S_SEL, S_SEARCH, S_ERR} pps_st_t;
	pps_st_t st_r, st_nxt;
	logic [5:0] ph_r, ph_nxt; // phase pointer
	pps_pkg::pps_loop_t stk_r [0:2];
	pps_pkg::pps_loop_t stk_nxt [0:2];
	logic [1:0] sp_r, sp_nxt; // loop depth in use
	logic trap_arm_r, trap_arm_nxt;
	logic [5:0] trap_ph_r, trap_ph_nxt;
	logic [15:0] rate_r, rate_nxt; // rate in force
	logic base_r, base_nxt; // rate in force valid
	logic dir_r, dir_nxt;
	logic [6:0] lbl_r, lbl_nxt;
	logic [5:0] srch_r, srch_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic rate_phase_r, rate_phase_nxt; // current phase is a rate phase, not refill or pause
	logic boot_r, boot_nxt;
	logic tenth_r, tenth_nxt; // running pause counts tenths
	pps_pkg::pps_pump_t pump_nxt;
	logic clr_nxt, err_nxt, rerr_nxt, buz_nxt, prompt_nxt;
	logic [6:0] dflt_nxt;
	logic ev_s, trig_s, prog_s, ev_d_r;
	logic [22:0] low_cnt_r, low_cnt_nxt;
	logic ev_low200;
	logic t_load, t_done;
	logic [9:0] t_tenths;
	logic [6:0] t_secs;
	logic fire;
	pps_pkg::pps_phase_t cur;
	// ==========================================
	// pin synchronisers
	pps_sync u_ev (.clk(clk), .rst_n(rst_n), .ce(ce), .d(event_n), .q(ev_s));
	pps_sync u_tr (.clk(clk), .rst_n(rst_n), .ce(ce), .d(trig_n), .q(trig_s));
	pps_sync u_pi (.clk(clk), .rst_n(rst_n), .ce(ce), .d(prog_in_n), .q(prog_s));
	// pause timer
	pps_timer u_tm (.clk(clk), .rst_n(rst_n), .ce(ce), .load(t_load), .tenths(t_tenths),
		.done(t_done), .secs_left(t_secs));
	// ==========================================
	// program write port, no reset on memory
	always_ff @(posedge clk) begin
		if (ce && wr_en && wr_addr >= `PPS_PHASE_FIRST && wr_addr <= `PPS_PHASE_MAX) begin
			mem[wr_addr] <= wr_data;
		end
	end
	assign cur = mem[ph_r];
	// event trap fire: edge or serial command
	assign fire = trap_arm_r && ((ev_d_r && !ev_s) || serial_event);
	assign ev_low200 = (low_cnt_r >= 23'(`PPS_LOW_CYC));
	// ==========================================
	// main next-state logic
	always_comb begin
		st_nxt = st_r;
		ph_nxt = ph_r;
		for (int i = 0; i < 3; i++) begin
			stk_nxt[i] = stk_r[i];
		end
		sp_nxt = sp_r;
		trap_arm_nxt = trap_arm_r;
		trap_ph_nxt = trap_ph_r;
		rate_nxt = rate_r;
		base_nxt = base_r;
		dir_nxt = dir_r;
		lbl_nxt = lbl_r;
		srch_nxt = srch_r;
		cnt_nxt = cnt_r;
		rate_phase_nxt = rate_phase_r;
		tenth_nxt = tenth_r;
		boot_nxt = 1'b0;
		pump_nxt = pump;
		clr_nxt = 1'b0;
		err_nxt = prog_error;
		rerr_nxt = range_error;
		buz_nxt = 1'b0;
		prompt_nxt = 1'b0;
		dflt_nxt = sel_default;
		t_load = 1'b0;
		t_tenths = 10'h000;
		low_cnt_nxt = ev_s ? 23'h000000 : (ev_low200 ? low_cnt_r : low_cnt_r + 23'h000001);
		case (st_r)
			S_IDLE: begin
				pump_nxt.run = 1'b0;
				buz_nxt = alarm_en && !boot_r;
				if (boot_r && lockout && mem[`PPS_PHASE_FIRST].fn == pps_pkg::FN_SEL) begin
					st_nxt = S_FETCH;
					ph_nxt = `PPS_PHASE_FIRST;
				end else if (start || !trig_s) begin
					st_nxt = S_FETCH;
					ph_nxt = `PPS_PHASE_FIRST;
					err_nxt = 1'b0;
					base_nxt = 1'b0;
					sp_nxt = 2'h0;
					trap_arm_nxt = 1'b0;
				end
			end
			S_FETCH: begin
				// default: move to next phase, saturate past max ends run
				if (ph_r >= `PPS_PHASE_MAX) begin
					ph_nxt = ph_r;
				end else begin
					ph_nxt = ph_r + 6'h01;
				end
				case (cur.fn)
					pps_pkg::FN_RATE: begin
						pump_nxt = '{run: 1'b1, rate: cur.rate, dir: cur.dir, refill: 1'b0};
						rate_nxt = cur.rate;
						base_nxt = 1'b1;
						rate_phase_nxt = 1'b1;
						st_nxt = S_PUMP;
					end
					pps_pkg::FN_REFILL: begin
						// reverse and return volume, clearing total
						pump_nxt.run = 1'b1;
						pump_nxt.refill = 1'b1;
						pump_nxt.dir = !dir_r;
						pump_nxt.rate = (cur.rate == 16'h0000) ? rate_r : cur.rate;
						clr_nxt = 1'b1;
						rate_phase_nxt = 1'b0;
						st_nxt = S_PUMP;
					end
					pps_pkg::FN_RAISE, pps_pkg::FN_LOWER: begin
						if (!base_r) begin
							err_nxt = 1'b1;
							st_nxt = S_IDLE;
						end else begin
							// adjust base, keep units
							rate_nxt = (cur.fn == pps_pkg::FN_RAISE) ? rate_r + cur.rate
								: rate_r - cur.rate;
							pump_nxt = '{run: 1'b1, rate: rate_nxt, dir: cur.dir, refill: 1'b0};
							rate_phase_nxt = 1'b1;
							st_nxt = S_PUMP;
						end
					end
					pps_pkg::FN_STOP: begin
						st_nxt = S_IDLE;
					end
					pps_pkg::FN_GOTO: begin
						ph_nxt = cur.param[5:0];
					end
					pps_pkg::FN_SEL: begin
						st_nxt = S_SEL;
						pump_nxt.run = 1'b0;
						base_nxt = 1'b0;
					end
					pps_pkg::FN_LABEL: begin
						ph_nxt = `PPS_PHASE_FIRST;
					end
					pps_pkg::FN_LOOP_BEGIN: begin
						// push, deepest layer kept at three
						if (sp_r < 2'h3) begin
							stk_nxt[sp_r] = '{begin_ph: ph_r, count: 7'h00};
							sp_nxt = sp_r + 2'h1;
						end
					end
					pps_pkg::FN_LOOP_ENDLESS, pps_pkg::FN_LOOP_COUNTED: begin
						if (sp_r == 2'h0) begin
							ph_nxt = `PPS_PHASE_FIRST;
							if (cur.fn == pps_pkg::FN_LOOP_COUNTED) begin
								// implied begin held one below phase 1, so the +1 on repeat lands on it
								stk_nxt[0] = '{begin_ph: 6'h00, count: 7'h01};
								sp_nxt = 2'h1;
								if (cur.param <= 7'h01) begin
									ph_nxt = ph_r + 6'h01;
									sp_nxt = 2'h0;
								end
							end
						end else if (cur.fn == pps_pkg::FN_LOOP_ENDLESS) begin
							// skip the begin phase itself, which would push again
							ph_nxt = stk_r[sp_r - 2'h1].begin_ph + 6'h01;
						end else if (stk_r[sp_r - 2'h1].count + 7'h01 >= cur.param) begin
							ph_nxt = (ph_r >= `PPS_PHASE_MAX) ? ph_r : ph_r + 6'h01;
							sp_nxt = sp_r - 2'h1;
						end else begin
							stk_nxt[sp_r - 2'h1].count = stk_r[sp_r - 2'h1].count + 7'h01;
							ph_nxt = stk_r[sp_r - 2'h1].begin_ph + 6'h01;
						end
					end
					pps_pkg::FN_PAUSE: begin
						pump_nxt.run = 1'b0;
						base_nxt = 1'b0;
						rate_phase_nxt = 1'b0;
						if (cur.param == 7'h00) begin
							st_nxt = S_WAIT;
						end else begin
							t_load = 1'b1;
							tenth_nxt = cur.tenths;
							t_tenths = cur.tenths ? 10'(cur.param) : 10'(cur.param) * 10'h00A;
							st_nxt = S_PAUSE;
						end
					end
					pps_pkg::FN_COND_GOTO: begin
						if (!prog_s) begin
							ph_nxt = cur.param[5:0];
						end
					end
					pps_pkg::FN_TRAP: begin
						trap_arm_nxt = 1'b1;
						trap_ph_nxt = cur.param[5:0];
						if (ev_low200) begin
							ph_nxt = cur.param[5:0];
							trap_arm_nxt = 1'b0;
						end
					end
					default: st_nxt = S_IDLE;
				endcase
				if (ph_r >= `PPS_PHASE_MAX && ph_nxt == ph_r && st_nxt == S_FETCH) begin
					st_nxt = S_IDLE;
				end
			end
			S_PUMP: begin
				if (pump_done) begin
					pump_nxt.run = 1'b0;
					st_nxt = S_FETCH;
				end
				if (foot_start && rate_phase_r) begin
					ph_nxt = `PPS_PHASE_FIRST;
					st_nxt = S_FETCH;
				end
			end
			S_PAUSE: begin
				if (t_done) begin
					st_nxt = S_FETCH;
				end
			end
			S_WAIT: begin
				buz_nxt = alarm_en;
				if (start || !trig_s) begin
					st_nxt = S_FETCH;
				end else if (other_key) begin
					st_nxt = S_IDLE;
				end
			end
			S_SEL: begin
				prompt_nxt = 1'b1;
				buz_nxt = alarm_en;
				if (sel_go) begin
					lbl_nxt = sel_label;
					dflt_nxt = sel_label;
					srch_nxt = ph_r;
					cnt_nxt = 6'h00;
					st_nxt = S_SEARCH;
				end
			end
			S_SEARCH: begin
				// forward then wrap, first match wins
				if (mem[srch_r].fn == pps_pkg::FN_LABEL && mem[srch_r].param == lbl_r) begin
					// resume after the label, which would otherwise jump to phase 1
					ph_nxt = (srch_r >= `PPS_PHASE_MAX) ? srch_r : srch_r + 6'h01;
					clr_nxt = 1'b1;
					st_nxt = S_FETCH;
				end else if (cnt_r == `PPS_PHASE_MAX - 6'h01) begin
					rerr_nxt = 1'b1;
					st_nxt = S_ERR;
				end else begin
					cnt_nxt = cnt_r + 6'h01;
					srch_nxt = (srch_r >= `PPS_PHASE_MAX) ? `PPS_PHASE_FIRST : srch_r + 6'h01;
				end
			end
			S_ERR: begin
				if (start || other_key) begin
					rerr_nxt = 1'b0;
					st_nxt = S_SEL;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
		if (fire && st_r != S_IDLE) begin
			ph_nxt = trap_ph_r;
			trap_arm_nxt = 1'b0;
			rerr_nxt = 1'b0;
			pump_nxt.run = 1'b0;
			st_nxt = S_FETCH;
		end
		if (pump_nxt.run) begin
			dir_nxt = pump_nxt.dir;
		end
	end
	// ==========================================
	// state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= S_IDLE;
			ph_r <= `PPS_PHASE_FIRST;
			for (int i = 0; i < 3; i++) begin
				stk_r[i] <= '0;
			end
			sp_r <= 2'h0;
			trap_arm_r <= 1'b0;
			trap_ph_r <= `PPS_PHASE_FIRST;
			rate_r <= 16'h0000;
			base_r <= 1'b0;
			dir_r <= 1'b0;
			lbl_r <= `PPS_SEL_LABEL_RST;
			srch_r <= `PPS_PHASE_FIRST;
			cnt_r <= 6'h00;
			rate_phase_r <= 1'b0;
			boot_r <= 1'b1;
			low_cnt_r <= 23'h000000;
			ev_d_r <= 1'b1;
			pump <= '0;
			clear_volume <= 1'b0;
			prog_error <= 1'b0;
			range_error <= 1'b0;
			buzzer <= 1'b0;
			sel_prompt <= 1'b0;
			sel_default <= `PPS_SEL_LABEL_RST;
			phase <= `PPS_PHASE_FIRST;
			pause_secs <= 7'h00;
			tenth_r <= 1'b0;
			running <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			for (int i = 0; i < 3; i++) begin
				stk_r[i] <= stk_nxt[i];
			end
			sp_r <= sp_nxt;
			trap_arm_r <= trap_arm_nxt;
			trap_ph_r <= trap_ph_nxt;
			rate_r <= rate_nxt;
			base_r <= base_nxt;
			dir_r <= dir_nxt;
			lbl_r <= lbl_nxt;
			srch_r <= srch_nxt;
			cnt_r <= cnt_nxt;
			rate_phase_r <= rate_phase_nxt;
			boot_r <= boot_nxt;
			low_cnt_r <= low_cnt_nxt;
			ev_d_r <= ev_s;
			pump <= pump_nxt;
			clear_volume <= clr_nxt;
			prog_error <= err_nxt;
			range_error <= rerr_nxt;
			buzzer <= buz_nxt;
			sel_prompt <= prompt_nxt;
			sel_default <= dflt_nxt;
			phase <= ph_nxt;
			pause_secs <= (st_r == S_PAUSE && tenth_r) ? 7'h01 : t_secs;
			tenth_r <= tenth_nxt;
			// running level follows the next state
			running <= (st_nxt != S_IDLE);
		end
	end
endmodule

/* verilog/pps_map.svh */
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH
// ==========================================
// phase memory
`define PPS_PHASE_MAX 6'h29
`define PPS_PHASE_FIRST 6'h01
`define PPS_LOOP_DEPTH 3
// ==========================================
// timing at 25 MHz
`define PPS_CLK_HZ 25000000
`define PPS_TENTH_NS 100000000
`define PPS_TENTH_CYC (`PPS_TENTH_NS / 40)
`define PPS_LOW_MS 200
`define PPS_LOW_CYC ((`PPS_LOW_MS * 25000))
`define PPS_SEL_LABEL_RST 7'h00
`endif

/* verilog/pps_pkg.sv */
package pps_pkg;
	// phase function codes
	typedef enum logic [3:0] {
		FN_RATE, FN_REFILL, FN_RAISE, FN_LOWER, FN_STOP, FN_GOTO, FN_SEL, FN_LABEL,
		FN_LOOP_BEGIN, FN_LOOP_ENDLESS, FN_LOOP_COUNTED, FN_PAUSE, FN_COND_GOTO, FN_TRAP
	} pps_fn_t;
	// one stored phase
	typedef struct packed {
		pps_fn_t fn;
		logic [6:0] param;
		logic tenths;
		logic [15:0] rate;
		logic dir;
	} pps_phase_t;
	// loop stack entry
	typedef struct packed {
		logic [5:0] begin_ph;
		logic [6:0] count;
	} pps_loop_t;
	// pump command to motor side
	typedef struct packed {
		logic run;
		logic [15:0] rate;
		logic dir;
		logic refill;
	} pps_pump_t;
endpackage

/* verilog/pps_sync.sv */
`timescale 1ns/1ns
// two-stage synchroniser for pin inputs
module pps_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic d,
	output logic q
);
	logic s1_r;
	logic s1_nxt;
	logic q_nxt;
	// ==========================================
	// next values
	always_comb begin
		s1_nxt = ce ? d : s1_r;
		q_nxt = ce ? s1_r : q;
	end
	// registers, reset high (idle pin level)
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 1'b1;
			q <= 1'b1;
		end else begin
			s1_r <= s1_nxt;
			q <= q_nxt;
		end
	end
endmodule

/* verilog/pps_timer.sv */
`timescale 1ns/1ns
`include "pps_map.svh"
// tenth-second pause timer
module pps_timer #(
	parameter int TENTH_CYC = `PPS_TENTH_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic load,
	input wire logic [9:0] tenths,
	output logic done,
	output logic [6:0] secs_left
);
	logic [21:0] pre_r;
	logic [21:0] pre_nxt;
	logic [9:0] left_r;
	logic [9:0] left_nxt;
	logic done_nxt;
	// ==========================================
	// countdown of tenths
	always_comb begin
		pre_nxt = pre_r;
		left_nxt = left_r;
		done_nxt = 1'b0;
		if (load) begin
			// start new pause
			pre_nxt = 22'(TENTH_CYC - 1);
			left_nxt = tenths;
		end else if (left_r != 10'h000) begin
			if (pre_r == 22'h000000) begin
				pre_nxt = 22'(TENTH_CYC - 1);
				left_nxt = left_r - 10'h001;
				done_nxt = (left_r == 10'h001);
			end else begin
				pre_nxt = pre_r - 22'h000001;
			end
		end
	end
	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_r <= 22'h000000;
			left_r <= 10'h000;
			done <= 1'b0;
		end else if (ce) begin
			pre_r <= pre_nxt;
			left_r <= left_nxt;
			done <= done_nxt;
		end
	end
	// seconds remaining, rounded up
	assign secs_left = 7'((left_r + 10'h009) / 10'h00A);
endmodule

/* dv/pps_sequencer_assertions.sv */
`timescale 1ns/1ns
// ==========================================
// port checker for the sequencer
module pps_sequencer_assertions (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic alarm_en,
	input wire pps_pkg::pps_pump_t pump,
	input wire logic clear_volume,
	input wire logic [5:0] phase,
	input wire logic running,
	input wire logic prog_error,
	input wire logic range_error,
	input wire logic buzzer,
	input wire logic sel_prompt
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ==========================================
	// assertions
	chk_phase_range: assert property (phase >= 6'h01 && phase <= 6'h29)
		else $error("phase outside the stored range");
	chk_start_runs: assert property (!running && start && ce && !prog_error &&
		!range_error |-> ##[1:3] running)
		else $error("start did not begin the program");
	chk_idle_quiet: assert property (!running && !$past(running) |-> !pump.run)
		else $error("pump runs while program stopped");
	chk_stop_buzz: assert property ($fell(running) && alarm_en && !prog_error
		|-> ##[0:2] buzzer)
		else $error("no buzzer after stop");
	chk_error_halts: assert property ($rose(prog_error) |-> ##[0:2] !running)
		else $error("program error did not halt");
	chk_refill_clear: assert property ($rose(pump.refill) |->
		(clear_volume || $past(clear_volume)) or ##1 clear_volume)
		else $error("refill without volume clear");
	chk_prompt_still: assert property (sel_prompt |-> !pump.run)
		else $error("pump runs during label entry");
	chk_miss_still: assert property (range_error |-> !pump.run)
		else $error("pump runs during range error");
	// main scenarios
	cover property ($rose(pump.refill));
	cover property ($rose(sel_prompt));
	cover property ($rose(prog_error));
	cover property ($rose(range_error));
endmodule

/* dv/pps_pump_model.sv */
`timescale 1ns/1ns
// ==========================================
// motor side: reports each volume done after a fixed run time
module pps_pump_model #(
	parameter int DELAY = 40 // running cycles per volume
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	output logic pump_done
);
	int cnt; // cycles run so far
	// counts running cycles, done stands one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			pump_done <= 1'b0;
		end else begin
			pump_done <= run && cnt == DELAY - 1;
			cnt <= (run && cnt < DELAY - 1) ? cnt + 1 : 0;
		end
	end
endmodule

/* dv/pps_sequencer_tb.sv */
`timescale 1ns/1ns
// ==========================================
// bench: loads programs, runs them, watches the pump command
module pps_sequencer_tb;
	logic clk = 1'b0; // 25 MHz
	logic rst_n = 1'b0; // held low at start
	logic ce = 1'b1; // always enabled
	logic foot_start = 1'b0; // foot switch pulse
	logic [5:0] kv = 6'h00; // key and pin pulses
	logic prog_in_n = 1'b1;
	logic lockout = 1'b0;
	logic alarm_en = 1'b0;
	logic wr_en = 1'b0;
	logic [5:0] wr_addr = 6'h00;
	pps_pkg::pps_phase_t wr_data = '0;
	logic [6:0] sel_label = 7'h00;
	logic start, other_key, serial_event, trig_n, event_n, sel_go, pump_done;
	pps_pkg::pps_pump_t pump;
	logic clear_volume, running, prog_error, range_error, buzzer, sel_prompt;
	logic [5:0] phase;
	logic [6:0] sel_default, pause_secs;
	logic [17:0] last_r = '1; // last pump command seen
	logic cv = 1'b0; // clear pulse seen
	int checks = 0;
	int n_mismatch = 0;
	assign start = kv[0];
	assign sel_go = kv[1];
	assign other_key = kv[2];
	assign serial_event = kv[3];
	assign trig_n = !kv[4];
	assign event_n = !kv[5];
	always #20 clk = ~clk;
	// remembers any clear pulse since the last start
	always @(clear_volume) begin
		if (clear_volume === 1'b1) begin
			cv = 1'b1;
		end
	end
	pps_sequencer dut (.clk, .rst_n, .ce, .start, .foot_start, .other_key, .serial_event,
		.trig_n, .event_n, .prog_in_n, .lockout, .alarm_en, .pump_done, .wr_en, .wr_addr,
		.wr_data, .sel_label, .sel_go, .pump, .clear_volume, .phase, .running, .prog_error,
		.range_error, .buzzer, .sel_prompt, .sel_default, .pause_secs);
	pps_pump_model #(.DELAY(40)) model (.clk, .rst_n, .run(pump.run), .pump_done);
	// ==========================================
	// tasks
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// phase write; codes 0..3 carry a rate, the rest a parameter, bit 15 marks tenths
	task automatic w(input logic [5:0] a, input logic [3:0] f, input logic [15:0] v);
		@(negedge clk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = '{pps_pkg::pps_fn_t'(f), f < 4 ? 7'h00 : v[6:0], f < 4 ? 1'b0 : v[15],
			f < 4 ? v : 16'h0000, 1'b0};
		@(negedge clk);
		wr_en = 1'b0;
	endtask
	// one key pulse, pins held low three cycles for the synchroniser
	task automatic p(input int k);
		@(negedge clk);
		kv[k] = 1'b1;
		repeat (k > 3 ? 3 : 1) @(negedge clk);
		kv[k] = 1'b0;
	endtask
	function automatic logic hit(input int c);
		case (c)
			0: return running === 1'b1;
			1: return running === 1'b0;
			2: return sel_prompt === 1'b1;
			3: return range_error === 1'b1;
			4: return prog_error === 1'b1;
			5: return range_error === 1'b0;
			default: return pump.run === 1'b1 && {pump.rate, pump.dir, pump.refill} !== last_r;
		endcase
	endfunction
	// bounded wait for a condition
	task automatic wt(input int c);
		int i;
		for (i = 0; i < 2000 && !hit(c); i++) @(negedge clk);
		if (i == 2000) begin
			n_mismatch++;
			$display("unexpected at %0t: wait %h got %h", $time, c, 0);
			stop_test();
		end
	endtask
	// next new pump command: rate, direction, refill
	task automatic er(input logic [17:0] e);
		wt(6);
		chk({pump.rate, pump.dir, pump.refill}, e);
		last_r = {pump.rate, pump.dir, pump.refill};
	endtask
	task automatic go();
		cv = 1'b0;
		last_r = '1;
		p(0);
	endtask
	task automatic rs(input logic lk);
		@(negedge clk);
		rst_n = 1'b0;
		lockout = lk;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask
	// ==========================================
	// tests
	initial begin
		rs(1'b0);
		alarm_en = 1'b1;
		w(1, 0, 16'h0064);
		w(2, 2, 16'h0005);
		w(3, 3, 16'h0014);
		w(4, 5, 16'h0006);
		w(5, 0, 16'h03E7);
		w(6, 0, 16'h00AA);
		w(7, 4, 16'h0000);
		go();
		er({16'h0064, 2'b00});
		er({16'h0069, 2'b00});
		er({16'h0055, 2'b00});
		er({16'h00AA, 2'b00});
		wt(1);
		repeat (3) @(negedge clk);
		chk(buzzer, 1'b1);
		go();
		er({16'h0064, 2'b00});
		wt(1);
		$display("test 1 done");
		rs(1'b0);
		alarm_en = 1'b0;
		w(1, 2, 16'h0005);
		go();
		wt(4);
		repeat (3) @(negedge clk);
		chk(running, 1'b0);
		rs(1'b0);
		w(1, 0, 16'h0032);
		w(2, 1, 16'h0000);
		w(3, 4, 16'h0000);
		go();
		er({16'h0032, 2'b00});
		er({16'h0032, 2'b11});
		chk(cv, 1'b1);
		wt(1);
		$display("test 2 done");
		w(1, 0, 16'h000A);
		w(2, 8, 16'h0000);
		w(3, 8, 16'h0000);
		w(4, 2, 16'h0001);
		w(5, 10, 16'h0002);
		w(6, 10, 16'h0002);
		w(7, 0, 16'h00F0);
		w(8, 4, 16'h0000);
		go();
		er({16'h000A, 2'b00});
		for (int k = 1; k <= 4; k++) er({16'h000A + k[15:0], 2'b00});
		er({16'h00F0, 2'b00});
		wt(1);
		$display("test 3 done");
		w(1, 12, 16'h0003);
		w(2, 0, 16'h0007);
		w(3, 0, 16'h0009);
		w(4, 4, 16'h0000);
		prog_in_n = 1'b0;
		go();
		er({16'h0009, 2'b00});
		wt(1);
		prog_in_n = 1'b1;
		go();
		er({16'h0007, 2'b00});
		wt(1);
		$display("test 4 done");
		w(1, 6, 16'h0000);
		w(2, 0, 16'h0003);
		w(3, 7, 16'h0007);
		w(4, 0, 16'h0004);
		w(5, 6, 16'h0000);
		w(6, 7, 16'h0009);
		w(7, 0, 16'h0005);
		w(8, 7, 16'h0002);
		rs(1'b1);
		wt(2);
		cv = 1'b0;
		sel_label = 7'h07; // operator label within 0..99
		p(1);
		er({16'h0004, 2'b00});
		chk(cv, 1'b1);
		wt(2);
		chk(sel_default, 7'h07);
		last_r = '1;
		p(1);
		er({16'h0004, 2'b00});
		wt(2);
		sel_label = 7'h09;
		p(1);
		er({16'h0005, 2'b00});
		wt(2);
		// select on phase 1 has run, pointer rests on phase 2
		chk(phase, 6'h02);
		sel_label = 7'h37;
		p(1);
		wt(3);
		p(2);
		wt(5);
		$display("test 5 done");
		rs(1'b0);
		w(1, 13, 16'h0004);
		w(2, 0, 16'h0014);
		w(3, 4, 16'h0000);
		w(4, 0, 16'h001E);
		w(5, 4, 16'h0000);
		go();
		er({16'h0014, 2'b00});
		p(3);
		er({16'h001E, 2'b00});
		wt(1);
		go();
		er({16'h0014, 2'b00});
		p(5);
		er({16'h001E, 2'b00});
		wt(1);
		$display("test 6 done");
		alarm_en = 1'b1;
		w(1, 11, 16'h0000);
		w(2, 0, 16'h0028);
		w(3, 4, 16'h0000);
		go();
		wt(0);
		repeat (4) @(negedge clk);
		chk(pump.run, 1'b0);
		chk(buzzer, 1'b1);
		p(4);
		er({16'h0028, 2'b00});
		wt(1);
		go();
		wt(0);
		repeat (4) @(negedge clk);
		p(2);
		wt(1);
		$display("test 7 done");
		w(1, 0, 16'h0011);
		w(2, 0, 16'h0022);
		go();
		er({16'h0011, 2'b00});
		er({16'h0022, 2'b00});
		@(negedge clk);
		foot_start = 1'b1;
		@(negedge clk);
		foot_start = 1'b0;
		er({16'h0011, 2'b00});
		wt(1);
		w(1, 13, 16'h0006);
		w(2, 0, 16'h0010);
		w(3, 8, 16'h0000);
		w(4, 2, 16'h0001);
		w(5, 9, 16'h0000);
		w(6, 0, 16'h0050);
		w(7, 4, 16'h0000);
		go();
		er({16'h0010, 2'b00});
		for (int k = 1; k <= 3; k++) er({16'h0010 + k[15:0], 2'b00});
		p(3);
		er({16'h0050, 2'b00});
		wt(1);
		$display("test 8 done");
		w(1, 11, 16'h0003);
		go();
		repeat (4) @(negedge clk);
		chk(pause_secs, 7'h03);
		w(1, 11, 16'h802D);
		rs(1'b0);
		go();
		repeat (4) @(negedge clk);
		chk(pause_secs, 7'h01);
		rs(1'b0);
		$display("test 9 done");
		stop_test();
	end
endmodule
bind pps_sequencer pps_sequencer_assertions chk (.clk, .rst_n, .ce, .start, .alarm_en, .pump,
	.clear_volume, .phase, .running, .prog_error, .range_error, .buzzer, .sel_prompt);
